//--- bench/sso_checker.sv
`timescale 1ns/1ps
module sso_checker #(
    parameter int NUM_DO = 4
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire sso_pkg::sso_meas_t    meas,
    input wire sso_pkg::sso_cfg_t     cfg,
    input wire logic [NUM_DO*4-1:0]   do_func,
    input wire logic [NUM_DO-1:0]     do_out,
    input wire logic [5:0]            alarm_code,
    input wire logic                  alarm_flag,
    input wire logic                  servo_ready_flag,
    input wire logic                  zero_speed_flag,
    input wire logic                  speed_arrive_flag,
    input wire logic                  torque_limited_flag,
    input wire logic                  running_flag,
    input wire logic                  brake_release_out
);
    function automatic logic [15:0] mag(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    sequence s_run;
        !$past(sys_rst) && !$past(sys_rst, 2);
    endsequence
    sequence s_over;
        s_run ##0 alarm_code == 6'h00 && mag(meas.speed) > cfg.speed_max;
    endsequence
    property p_code; alarm_flag == (alarm_code != 6'h00); endproperty
    property p_ready; alarm_flag |-> !servo_ready_flag; endproperty
    property p_over; s_over |=> alarm_code == 6'h01; endproperty
    property p_zero; s_run ##0 mag(meas.speed) < cfg.zero_speed |=> zero_speed_flag; endproperty
    property p_spd; s_run ##0 mag(meas.speed) <= cfg.speed_target |=> !speed_arrive_flag;
    endproperty
    property p_tlim; s_run ##0 mag(meas.torque) >= cfg.torque_limit |=> torque_limited_flag;
    endproperty
    property p_brake; brake_release_out == running_flag; endproperty
    property p_force; s_run ##0 (do_func[7:4] == 4'h1)[*3] |-> do_out[1]; endproperty
    property p_sel;
        s_run ##0 do_func[3:0] == 4'h2 && $past(do_func[3:0]) == 4'h2
            |-> do_out[0] == $past(servo_ready_flag);
    endproperty
    a_code: assert property (p_code) else $error("alarm flag and code differ");
    a_ready: assert property (p_ready) else $error("ready during alarm");
    a_over: assert property (p_over) else $error("overspeed code missing");
    a_zero: assert property (p_zero) else $error("zero speed flag low");
    a_spd: assert property (p_spd) else $error("speed arrive flag high");
    a_tlim: assert property (p_tlim) else $error("torque limit flag low");
    a_brake: assert property (p_brake) else $error("brake differs from run");
    a_force: assert property (p_force) else $error("forced output low");
    a_sel: assert property (p_sel) else $error("pin0 not ready flag");
endmodule

//--- bench/sso_host.sv
`timescale 1ns/1ps
module sso_host (
    input  wire logic       clk,
    input  wire logic [3:0] do_out,
    input  wire logic [5:0] alarm_code,
    output logic      [3:0] do_seen,
    output logic      [5:0] code_seen
);
    // controller samples the status lines once per clock
    always_ff @(posedge clk) begin
        do_seen   <= do_out;
        code_seen <= alarm_code;
    end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic clk = 0, sys_rst = 1, en = 1, mode = 1, clr = 0, pwr = 1;
    logic a = 0, b = 0, z = 0, u = 1, v = 0, w = 0, cw = 0, ccw = 0, cmd = 0;
    logic [15:0] fn = 16'h1110;
    sso_pkg::sso_meas_t meas = '0;
    sso_pkg::sso_cfg_t cfg = {16'h000a, 16'h0005, 16'h0002, 16'h0032, 16'h003c, 16'h0032,
        16'h00c8, 16'h03e8, 16'h03e8, 16'h0064, 16'h0002, 16'h0002};
    logic [3:0] do_out, host_do;
    logic [5:0] code, host_code;
    logic [5:0] codes [8] = '{6'h01, 6'h04, 6'h05, 6'h07, 6'h09, 6'h1d, 6'h1e, 6'h20};
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    sso_top #(.TICK_CYC(20), .Z_LOST_EDGES(8)) dut_u (
        .clk, .sys_rst, .meas, .cfg, .do_func(fn), .servo_enable(en), .pos_mode(mode),
        .alarm_clear(clr), .main_power_ok_in(pwr), .enc_a_in(a), .enc_b_in(b), .enc_z_in(z),
        .enc_u_in(u), .enc_v_in(v), .enc_w_in(w), .cw_travel_limit_in(cw),
        .ccw_travel_limit_in(ccw), .cmd_pulse_in(cmd), .do_out, .alarm_code(code),
        .alarm_flag(), .servo_ready_flag(), .zero_speed_flag(), .position_arrive_flag(),
        .near_position_flag(), .speed_arrive_flag(), .torque_arrive_flag(),
        .brake_release_out(), .running_flag(), .torque_limited_flag(), .speed_limited_flag());
    sso_host host_u (.clk, .do_out, .alarm_code(code), .do_seen(host_do), .code_seen(host_code));
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic set_st(input logic signed [15:0] s, t, d, input logic m, e);
        meas = '{s, t, d};
        mode = m;
        en = e;
    endtask
    // ----------------------------------------------------------------
    // pin0 walks every function, other pins stay forced on
    // ----------------------------------------------------------------
    task automatic sweep(input logic [12:0] exp);
        for (int f = 0; f < 14; f++) begin
            fn[3:0] = 4'(f);
            wt(3);
            `CHK("pin0", (f < 13) ? exp[f] : 1'h0, host_do[0])
            `CHK("pins", 3'h7, host_do[3:1])
        end
    endtask
    // fault k: 1 4 5 7 9 29 30 32
    task automatic apply(input int k, input logic on);
        case (k)
            0: meas.speed = on ? 16'sh07d0 : 16'sh0064;
            1: meas.pos_dev = on ? 16'sh07d0 : 16'sh0003;
            2: cmd = on & ~cmd;
            3: {cw, ccw} = {on, on};
            4: {a, b} = {2{on & ~a}};
            5: meas.torque = on ? 16'sh00c8 : 16'sh0032;
            6: a = on & ~a;
            default: u = ~on;
        endcase
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        wt(12);
        sys_rst = 0;
        wt(3);
        set_st(16'sh0064, 16'sh0032, 16'sh0003, 1, 1);
        sweep(13'h0b66);
        set_st(-16'sh0005, -16'sh0046, 16'sh0001, 0, 0);
        sweep(13'h0896);
        $display("test flags done");
        pwr = 0;
        fn[3:0] = 4'h2;
        wt(6);
        `CHK("ready nopwr", 1'h0, host_do[0])
        pwr = 1;
        fn = 16'h8932;
        set_st(16'sh0064, 16'sh0032, 16'sh0003, 1, 1);
        wt(6);
        `CHK("idle pins", 4'hd, host_do)
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 100; i++) begin
                apply(k, 1);
                wt(1);
            end
            `CHK("code", codes[k], host_code)
            `CHK("alarm pins", 4'h2, host_do)
            apply(k, 0);
            z = 1;
            wt(1);
            z = 0;
            clr = 1;
            wt(25);
            clr = 0;
            wt(3);
            `CHK("cleared", 6'h00, host_code)
        end
        $display("test alarms done");
        u = 0;
        wt(4);
        `CHK("uvw fault", 6'h20, host_code)
        u = 1;
        sys_rst = 1;
        wt(2);
        sys_rst = 0;
        wt(6);
        `CHK("reset code", 6'h00, host_code)
        `CHK("reset pins", 4'hd, host_do)
        $display("test reset done");
        give_verdict();
    end
endmodule
bind sso_top sso_checker #(.NUM_DO(NUM_DO)) chk_u (.clk, .sys_rst, .meas, .cfg, .do_func,
    .do_out, .alarm_code, .alarm_flag, .servo_ready_flag, .zero_speed_flag, .speed_arrive_flag,
    .torque_limited_flag, .running_flag, .brake_release_out);

//--- rtl/sso_out_sel.sv
`timescale 1ns/1ps
module sso_out_sel #(
    parameter int FN_W   = 4,
    parameter int NUM_FN = 13
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [FN_W-1:0]   func_sel,
    input  wire logic [NUM_FN-1:0] func_vec,
    output logic                   pin_out
);
    // ----------------------------------------------------------------
    // function selection
    // ----------------------------------------------------------------
    wire sel_valid;
    wire next_pin_out;

    assign sel_valid    = (32'(func_sel) < NUM_FN);
    // out-of-range codes behave as forced off
    assign next_pin_out = sel_valid ? func_vec[func_sel] : 1'b0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
        end
    end
endmodule

//--- rtl/sso_pkg.sv
package sso_pkg;

    // ----------------------------------------------------------------
    // widths and sizes
    // ----------------------------------------------------------------
    localparam int VAL_W   = 16;
    localparam int FN_W    = 4;
    localparam int NUM_FN  = 13;
    localparam int CODE_W  = 6;
    localparam int NUM_DO  = 4;
    localparam int CNT_W   = 16;

    // ----------------------------------------------------------------
    // output function codes
    // ----------------------------------------------------------------
    localparam logic [FN_W-1:0] FN_FORCE_OFF     = 4'h0;
    localparam logic [FN_W-1:0] FN_FORCE_ON      = 4'h1;
    localparam logic [FN_W-1:0] FN_READY         = 4'h2;
    localparam logic [FN_W-1:0] FN_ALARM         = 4'h3;
    localparam logic [FN_W-1:0] FN_ZERO_SPEED    = 4'h4;
    localparam logic [FN_W-1:0] FN_POS_ARRIVE    = 4'h5;
    localparam logic [FN_W-1:0] FN_SPEED_ARRIVE  = 4'h6;
    localparam logic [FN_W-1:0] FN_TORQUE_ARRIVE = 4'h7;
    localparam logic [FN_W-1:0] FN_BRAKE         = 4'h8;
    localparam logic [FN_W-1:0] FN_RUNNING       = 4'h9;
    localparam logic [FN_W-1:0] FN_NEAR_POS      = 4'ha;
    localparam logic [FN_W-1:0] FN_TORQUE_LIM    = 4'hb;
    localparam logic [FN_W-1:0] FN_SPEED_LIM     = 4'hc;

    // ----------------------------------------------------------------
    // alarm codes
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] ALM_NONE      = 6'h00;
    localparam logic [CODE_W-1:0] ALM_OVERSPEED = 6'h01;
    localparam logic [CODE_W-1:0] ALM_POS_DEV   = 6'h04;
    localparam logic [CODE_W-1:0] ALM_CMD_FREQ  = 6'h05;
    localparam logic [CODE_W-1:0] ALM_TRAVEL    = 6'h07;
    localparam logic [CODE_W-1:0] ALM_ENC_ABZ   = 6'h09;
    localparam logic [CODE_W-1:0] ALM_USER_LOAD = 6'h1d;
    localparam logic [CODE_W-1:0] ALM_Z_LOST    = 6'h1e;
    localparam logic [CODE_W-1:0] ALM_UVW_CODE  = 6'h20;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 40_000_000;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int Z_LOST_EDGES = 10000;

    // ----------------------------------------------------------------
    // synchroniser bit positions
    // ----------------------------------------------------------------
    localparam int SYNC_W  = 10;
    localparam int S_PWR   = 0;
    localparam int S_A     = 1;
    localparam int S_B     = 2;
    localparam int S_Z     = 3;
    localparam int S_U     = 4;
    localparam int S_V     = 5;
    localparam int S_W     = 6;
    localparam int S_CW    = 7;
    localparam int S_CCW   = 8;
    localparam int S_PULSE = 9;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [SYNC_W-1:0] SYNC_RST = 10'h000;
    localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
    localparam logic [1:0]        SYNC_AGE_RST  = 2'h0;
    localparam logic [1:0]        SYNC_AGE_FULL = 2'h3;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [VAL_W-1:0] speed;
        logic signed [VAL_W-1:0] torque;
        logic signed [VAL_W-1:0] pos_dev;
    } sso_meas_t;

    typedef struct packed {
        logic [VAL_W-1:0] zero_speed;
        logic [VAL_W-1:0] pos_arrive;
        logic [VAL_W-1:0] pos_near;
        logic [VAL_W-1:0] speed_target;
        logic [VAL_W-1:0] torque_target;
        logic [VAL_W-1:0] torque_limit;
        logic [VAL_W-1:0] speed_limit;
        logic [VAL_W-1:0] speed_max;
        logic [VAL_W-1:0] pos_tol;
        logic [VAL_W-1:0] load_level;
        logic [VAL_W-1:0] load_ms;
        logic [VAL_W-1:0] cmd_max_per_ms;
    } sso_cfg_t;

    typedef enum logic [0:0] {
        ST_CLEAR = 1'b0,
        ST_FAULT = 1'b1
    } sso_alm_state_t;

    function automatic logic [VAL_W-1:0] sso_abs(input logic signed [VAL_W-1:0] v);
        sso_abs = v[VAL_W-1] ? VAL_W'(-v) : VAL_W'(v);
    endfunction

endpackage

//--- rtl/sso_top.sv
`timescale 1ns/1ps
module sso_top #(
    parameter int NUM_DO       = sso_pkg::NUM_DO,
    parameter int TICK_CYC     = sso_pkg::TICK_CYC,
    parameter int Z_LOST_EDGES = sso_pkg::Z_LOST_EDGES
) (
    input  wire logic                                  clk,
    input  wire logic                                  sys_rst,
    input  wire sso_pkg::sso_meas_t                    meas,
    input  wire sso_pkg::sso_cfg_t                     cfg,
    input  wire logic [NUM_DO*sso_pkg::FN_W-1:0]       do_func,
    input  wire logic                                  servo_enable,
    input  wire logic                                  pos_mode,
    input  wire logic                                  alarm_clear,
    input  wire logic                                  main_power_ok_in,
    input  wire logic                                  enc_a_in,
    input  wire logic                                  enc_b_in,
    input  wire logic                                  enc_z_in,
    input  wire logic                                  enc_u_in,
    input  wire logic                                  enc_v_in,
    input  wire logic                                  enc_w_in,
    input  wire logic                                  cw_travel_limit_in,
    input  wire logic                                  ccw_travel_limit_in,
    input  wire logic                                  cmd_pulse_in,
    output logic [NUM_DO-1:0]                          do_out,
    output logic [sso_pkg::CODE_W-1:0]                 alarm_code,
    output logic                                       alarm_flag,
    output logic                                       servo_ready_flag,
    output logic                                       zero_speed_flag,
    output logic                                       position_arrive_flag,
    output logic                                       near_position_flag,
    output logic                                       speed_arrive_flag,
    output logic                                       torque_arrive_flag,
    output logic                                       brake_release_out,
    output logic                                       running_flag,
    output logic                                       torque_limited_flag,
    output logic                                       speed_limited_flag
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [sso_pkg::SYNC_W-1:0] sync_meta;
    logic [sso_pkg::SYNC_W-1:0] sync_pin;
    logic [sso_pkg::SYNC_W-1:0] sync_prev;
    wire  [sso_pkg::SYNC_W-1:0] pin_raw;
    // the ABZ and UVW fault detectors wait until every sync stage holds a real sample
    logic [1:0]                 sync_age;
    wire                        pins_valid;

    assign pin_raw = {cmd_pulse_in, ccw_travel_limit_in, cw_travel_limit_in,
                      enc_w_in, enc_v_in, enc_u_in, enc_z_in, enc_b_in,
                      enc_a_in, main_power_ok_in};
    assign pins_valid = (sync_age == sso_pkg::SYNC_AGE_FULL);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_meta <= sso_pkg::SYNC_RST;
            sync_pin  <= sso_pkg::SYNC_RST;
            sync_prev <= sso_pkg::SYNC_RST;
            sync_age  <= sso_pkg::SYNC_AGE_RST;
        end else begin
            sync_meta <= pin_raw;
            sync_pin  <= sync_meta;
            sync_prev <= sync_pin;
            sync_age  <= pins_valid ? sync_age : sync_age + 2'h1;
        end
    end

    wire pwr_ok;
    wire a_chg;
    wire b_chg;
    wire a_rise;
    wire z_rise;
    wire pulse_rise;

    assign pwr_ok     = sync_pin[sso_pkg::S_PWR];
    assign a_chg      = sync_pin[sso_pkg::S_A] ^ sync_prev[sso_pkg::S_A];
    assign b_chg      = sync_pin[sso_pkg::S_B] ^ sync_prev[sso_pkg::S_B];
    assign a_rise     = sync_pin[sso_pkg::S_A] & ~sync_prev[sso_pkg::S_A];
    assign z_rise     = sync_pin[sso_pkg::S_Z] & ~sync_prev[sso_pkg::S_Z];
    assign pulse_rise = sync_pin[sso_pkg::S_PULSE] & ~sync_prev[sso_pkg::S_PULSE];

    // ----------------------------------------------------------------
    // magnitudes
    // ----------------------------------------------------------------
    wire [sso_pkg::VAL_W-1:0] speed_mag;
    wire [sso_pkg::VAL_W-1:0] torque_mag;
    wire [sso_pkg::VAL_W-1:0] dev_mag;

    assign speed_mag  = sso_pkg::sso_abs(meas.speed);
    assign torque_mag = sso_pkg::sso_abs(meas.torque);
    assign dev_mag    = sso_pkg::sso_abs(meas.pos_dev);

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt;
    wire         tick;

    assign tick = (tick_cnt == 32'(TICK_CYC - 1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // command pulse rate per tick window
    // ----------------------------------------------------------------
    logic [sso_pkg::CNT_W-1:0] pulse_cnt;
    wire                       pulse_sat;

    assign pulse_sat = &pulse_cnt;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt <= sso_pkg::CNT_RST;
        end else if (tick) begin
            pulse_cnt <= sso_pkg::CNT_RST;
        end else if (pulse_rise && !pulse_sat) begin
            pulse_cnt <= pulse_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // user overload timer
    // ----------------------------------------------------------------
    logic [sso_pkg::CNT_W-1:0] load_cnt;
    wire                       load_high;

    assign load_high = (torque_mag > cfg.load_level);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_cnt <= sso_pkg::CNT_RST;
        end else if (!load_high) begin
            load_cnt <= sso_pkg::CNT_RST;
        end else if (tick && !(&load_cnt)) begin
            load_cnt <= load_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // index pulse watch: a edges counted since last index
    // ----------------------------------------------------------------
    logic [31:0] z_gap_cnt;
    wire         z_gap_full;

    assign z_gap_full = (z_gap_cnt >= 32'(Z_LOST_EDGES));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            z_gap_cnt <= 32'h0000_0000;
        end else if (z_rise) begin
            z_gap_cnt <= 32'h0000_0000;
        end else if (a_rise && !z_gap_full) begin
            z_gap_cnt <= z_gap_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // fault detectors
    // ----------------------------------------------------------------
    wire det_overspeed;
    wire det_pos_dev;
    wire det_cmd_freq;
    wire det_travel;
    wire det_enc_abz;
    wire det_user_load;
    wire det_z_lost;
    wire det_uvw;
    wire uvw_all0;
    wire uvw_all1;
    wire any_det;

    assign det_overspeed = (speed_mag > cfg.speed_max);
    assign det_pos_dev   = pos_mode && (dev_mag > cfg.pos_tol);
    assign det_cmd_freq  = (pulse_cnt > cfg.cmd_max_per_ms);
    // both limits asserted at once cannot be a real travel position
    assign det_travel    = sync_pin[sso_pkg::S_CW] & sync_pin[sso_pkg::S_CCW];
    // both quadrature lines flipping in one sample is a lost state
    assign det_enc_abz   = pins_valid & a_chg & b_chg;
    assign det_user_load = load_high && (load_cnt > cfg.load_ms);
    assign det_z_lost    = z_gap_full;
    assign uvw_all0      = ~|sync_pin[sso_pkg::S_W:sso_pkg::S_U];
    assign uvw_all1      = &sync_pin[sso_pkg::S_W:sso_pkg::S_U];
    assign det_uvw       = pins_valid & (uvw_all0 | uvw_all1);

    assign any_det = det_overspeed | det_pos_dev | det_cmd_freq | det_travel |
                     det_enc_abz | det_user_load | det_z_lost | det_uvw;

    // lowest code wins when several faults hit together
    wire [sso_pkg::CODE_W-1:0] pick_code;

    assign pick_code =
        det_overspeed ? sso_pkg::ALM_OVERSPEED :
        det_pos_dev   ? sso_pkg::ALM_POS_DEV   :
        det_cmd_freq  ? sso_pkg::ALM_CMD_FREQ  :
        det_travel    ? sso_pkg::ALM_TRAVEL    :
        det_enc_abz   ? sso_pkg::ALM_ENC_ABZ   :
        det_user_load ? sso_pkg::ALM_USER_LOAD :
        det_z_lost    ? sso_pkg::ALM_Z_LOST    :
        det_uvw       ? sso_pkg::ALM_UVW_CODE  :
                        sso_pkg::ALM_NONE;

    // ----------------------------------------------------------------
    // alarm latch
    // ----------------------------------------------------------------
    sso_pkg::sso_alm_state_t   alm_state;
    sso_pkg::sso_alm_state_t   next_alm_state;
    logic [sso_pkg::CODE_W-1:0] next_alarm_code;

    always_comb begin
        next_alm_state  = alm_state;
        next_alarm_code = alarm_code;
        case (alm_state)
            sso_pkg::ST_CLEAR: begin
                if (any_det) begin
                    next_alm_state  = sso_pkg::ST_FAULT;
                    next_alarm_code = pick_code;
                end
            end
            sso_pkg::ST_FAULT: begin
                // clear is refused while a cause still stands
                if (alarm_clear && !any_det) begin
                    next_alm_state  = sso_pkg::ST_CLEAR;
                    next_alarm_code = sso_pkg::ALM_NONE;
                end
            end
            default: begin
                next_alm_state  = sso_pkg::ST_CLEAR;
                next_alarm_code = sso_pkg::ALM_NONE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alm_state  <= sso_pkg::ST_CLEAR;
            alarm_code <= sso_pkg::ALM_NONE;
        end else begin
            alm_state  <= next_alm_state;
            alarm_code <= next_alarm_code;
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    wire next_alarm;
    wire next_ready;
    wire next_zero_speed;
    wire next_pos_arrive;
    wire next_near_pos;
    wire next_speed_arrive;
    wire next_torque_arrive;
    wire next_running;
    wire next_brake;
    wire next_torque_lim;
    wire next_speed_lim;

    // taken from the next latch state so ready and alarm move with it
    assign next_alarm         = (next_alm_state == sso_pkg::ST_FAULT);
    assign next_ready         = pwr_ok && !next_alarm;
    assign next_zero_speed    = (speed_mag < cfg.zero_speed);
    assign next_pos_arrive    = pos_mode && (dev_mag < cfg.pos_arrive);
    assign next_near_pos      = pos_mode && (dev_mag < cfg.pos_near);
    assign next_speed_arrive  = (speed_mag > cfg.speed_target);
    assign next_torque_arrive = (torque_mag > cfg.torque_target);
    assign next_running       = servo_enable && next_ready;
    // brake is released only while the motor is energised
    assign next_brake         = next_running;
    assign next_torque_lim    = (torque_mag >= cfg.torque_limit);
    assign next_speed_lim     = (speed_mag >= cfg.speed_limit);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_flag           <= 1'b0;
            servo_ready_flag     <= 1'b0;
            zero_speed_flag      <= 1'b0;
            position_arrive_flag <= 1'b0;
            near_position_flag   <= 1'b0;
            speed_arrive_flag    <= 1'b0;
            torque_arrive_flag   <= 1'b0;
            running_flag         <= 1'b0;
            brake_release_out    <= 1'b0;
            torque_limited_flag  <= 1'b0;
            speed_limited_flag   <= 1'b0;
        end else begin
            alarm_flag           <= next_alarm;
            servo_ready_flag     <= next_ready;
            zero_speed_flag      <= next_zero_speed;
            position_arrive_flag <= next_pos_arrive;
            near_position_flag   <= next_near_pos;
            speed_arrive_flag    <= next_speed_arrive;
            torque_arrive_flag   <= next_torque_arrive;
            running_flag         <= next_running;
            brake_release_out    <= next_brake;
            torque_limited_flag  <= next_torque_lim;
            speed_limited_flag   <= next_speed_lim;
        end
    end

    // ----------------------------------------------------------------
    // function vector indexed by function code
    // ----------------------------------------------------------------
    logic [sso_pkg::NUM_FN-1:0] func_vec;

    always_comb begin
        func_vec                                = '0;
        func_vec[sso_pkg::FN_FORCE_OFF]     = 1'b0;
        func_vec[sso_pkg::FN_FORCE_ON]      = 1'b1;
        func_vec[sso_pkg::FN_READY]         = servo_ready_flag;
        func_vec[sso_pkg::FN_ALARM]         = alarm_flag;
        func_vec[sso_pkg::FN_ZERO_SPEED]    = zero_speed_flag;
        func_vec[sso_pkg::FN_POS_ARRIVE]    = position_arrive_flag;
        func_vec[sso_pkg::FN_SPEED_ARRIVE]  = speed_arrive_flag;
        func_vec[sso_pkg::FN_TORQUE_ARRIVE] = torque_arrive_flag;
        func_vec[sso_pkg::FN_BRAKE]         = brake_release_out;
        func_vec[sso_pkg::FN_RUNNING]       = running_flag;
        func_vec[sso_pkg::FN_NEAR_POS]      = near_position_flag;
        func_vec[sso_pkg::FN_TORQUE_LIM]    = torque_limited_flag;
        func_vec[sso_pkg::FN_SPEED_LIM]     = speed_limited_flag;
    end

    // ----------------------------------------------------------------
    // output pins, one selector each
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DO; gi = gi + 1) begin : g_do
            sso_out_sel #(
                .FN_W   (sso_pkg::FN_W),
                .NUM_FN (sso_pkg::NUM_FN)
            ) u_sel (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .func_sel (do_func[gi*sso_pkg::FN_W +: sso_pkg::FN_W]),
                .func_vec (func_vec),
                .pin_out  (do_out[gi])
            );
        end
    endgenerate

endmodule
